/* File: sacr_host.sv */
// Host end: shifts one 11-bit command frame out per request.
// Assumes requests come from logic on clk; link clock is made by a divider here.
`timescale 1ns/1ps
module sacr_host
  import sacr_pkg::*;
#(
  parameter int HALF_CYCLES = `SACR_HALF_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Link.
  sacr_if.host lnk,
  // User request.
  input wire logic req,
  input wire logic [`SACR_SEL_BITS-1:0] sel,
  input wire sacr_func_t func,
  input wire sacr_val_t val,
  output logic busy
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  initial begin
    if (HALF_CYCLES < `SACR_HALF_CYCLES) $error("Link clock would exceed 500 kHz.");
  end

  sacr_hstate_t st_ff;
  sacr_frame_t sh_ff;
  logic [3:0] cnt_ff;
  logic [CW-1:0] div_ff;
  logic sclk_ff, data_ff, en_n_ff, busy_ff;
  logic tick;

  assign tick = (div_ff == CW'(HALF_CYCLES - 1));

  // Half-period divider keeps the link clock at or below its ceiling.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= '0;
    end else if (ce) begin
      div_ff <= (st_ff == SACR_H_IDLE || tick) ? '0 : div_ff + CW'(1);
    end
  end

  // Frame sequencer: data changes on the falling edge, stable at rising. 
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= SACR_H_IDLE;
      sh_ff <= '0;
      cnt_ff <= 4'h0;
      sclk_ff <= 1'b0;
      data_ff <= 1'b0;
      en_n_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else if (ce) begin
      unique case (st_ff)
        SACR_H_IDLE: begin
          if (req) begin
            sh_ff <= {sel, func, val};
            en_n_ff <= 1'b0;
            busy_ff <= 1'b1;
            cnt_ff <= 4'h0;
            st_ff <= SACR_H_LOW;
          end
        end
        SACR_H_LOW: begin
          data_ff <= sh_ff[`SACR_FRAME_BITS-1];
          if (tick) begin
            sclk_ff <= 1'b1;
            st_ff <= SACR_H_HIGH;
          end
        end
        SACR_H_HIGH: begin
          if (tick) begin
            sclk_ff <= 1'b0;
            sh_ff <= {sh_ff[`SACR_FRAME_BITS-2:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
            st_ff <= (cnt_ff == 4'(`SACR_FRAME_BITS - 1)) ? SACR_H_DONE : SACR_H_LOW;
          end
        end
        SACR_H_DONE: begin
          if (tick) begin
            en_n_ff <= 1'b1;
            busy_ff <= 1'b0;
            st_ff <= SACR_H_IDLE;
          end
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_ff;
  assign lnk.data = data_ff;
  assign lnk.en_n = en_n_ff;
  assign busy = busy_ff;
endmodule // sacr_host

/* File: sacr_map.svh */
// Constants for the serial audio control link: frame layout and timing.
// Assumes inclusion by the package, which both link ends import; definitions only.
`ifndef SACR_MAP_SVH
`define SACR_MAP_SVH
`define SACR_FRAME_BITS 11
`define SACR_SEL_BITS 2
`define SACR_FUNC_BITS 3
`define SACR_VAL_BITS 6
`define SACR_SEL_CODE 2'h2
`define SACR_FUNC_LSB 6
`define SACR_VAL_LSB 0
`define SACR_SEL_LSB 9
`define SACR_NUM_FUNCS 8
`define SACR_SET_RESET 6'h00
`define SACR_CLK_PERIOD_NS 100
`define SACR_LINK_MIN_PERIOD_NS 2000
`define SACR_HALF_CYCLES ((`SACR_LINK_MIN_PERIOD_NS / 2 + `SACR_CLK_PERIOD_NS - 1) / `SACR_CLK_PERIOD_NS)
`endif

/* File: sacr_pkg.sv */
// Types shared by both ends of the serial audio control link.
// Assumes sacr_map.svh is on the include path.
`include "sacr_map.svh"
package sacr_pkg;
  typedef logic [`SACR_FUNC_BITS-1:0] sacr_func_t;
  typedef logic [`SACR_VAL_BITS-1:0] sacr_val_t;
  typedef logic [`SACR_FRAME_BITS-1:0] sacr_frame_t;
  typedef enum logic [1:0] {
    SACR_H_IDLE = 2'h0,
    SACR_H_LOW = 2'h1,
    SACR_H_HIGH = 2'h3,
    SACR_H_DONE = 2'h2
  } sacr_hstate_t;
endpackage

/* File: sacr_if.sv */
// Three-wire control link joining the host end and the device end.
// Assumes the testbench instantiates it and wires both modports.
`timescale 1ns/1ps
interface sacr_if;
  logic data;
  logic sclk;
  logic en_n;
  // The host drives all three lines.
  modport host (output data, output sclk, output en_n);
  // The device only listens.
  modport device (input data, input sclk, input en_n);
endinterface // sacr_if

/* File: sacr_device.sv */
// Device end: receives command frames and holds eight six-bit settings.
// Assumes link lines are asynchronous to clk; they are synchronised here.
`timescale 1ns/1ps
// Functional notes
// - Frame is exactly eleven bits.
// - Leading bits one then zero select device.
// - Three-bit function then six-bit value.
// - Data sampled on rising link clock.
// - Host keeps link clock at most 500 kHz.
// - Enable active low gates data and clock.
// - Shift while enabled; settings unchanged.
// - Enable rise latches and executes frame.
// - Host parks unused selectors on open codes.
module sacr_device
  import sacr_pkg::*;
#(
  parameter int NUM_FUNCS = `SACR_NUM_FUNCS
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Link.
  sacr_if.device lnk,
  // Settings and update strobe.
  output logic [NUM_FUNCS*`SACR_VAL_BITS-1:0] settings,
  output logic upd,
  output sacr_func_t upd_func
);
  initial begin
    if (NUM_FUNCS != (1 << `SACR_FUNC_BITS)) $error("NUM_FUNCS must match the function field.");
  end

  logic [2:0] s1_ff, s2_ff, s3_ff;
  sacr_frame_t sh_ff;
  logic [4:0] cnt_ff;
  sacr_val_t set_ff [NUM_FUNCS];
  logic upd_ff;
  sacr_func_t upd_func_ff;
  logic sclk_rise, en_rise, en_act;

  // Two-stage synchronisers; the third stage feeds edge detection only.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      s3_ff <= 3'h1;
    end else if (ce) begin
      s1_ff <= {lnk.data, lnk.sclk, lnk.en_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign en_act = !s2_ff[0];
  assign sclk_rise = s2_ff[1] && !s3_ff[1] && en_act;
  assign en_rise = s2_ff[0] && !s3_ff[0];

  // Shift register; counter saturates so overlong frames are rejected.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= '0;
      cnt_ff <= 5'h00;
    end else if (ce) begin
      if (en_rise) begin
        cnt_ff <= 5'h00;
      end else if (sclk_rise) begin
        sh_ff <= {sh_ff[`SACR_FRAME_BITS-2:0], s2_ff[2]};
        if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  // Execute only a complete, selected frame; otherwise keep every setting.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_FUNCS; i++) set_ff[i] <= `SACR_SET_RESET;
      upd_ff <= 1'b0;
      upd_func_ff <= '0;
    end else if (ce) begin
      upd_ff <= 1'b0;
      if (en_rise && cnt_ff == 5'(`SACR_FRAME_BITS)
          && sh_ff[`SACR_SEL_LSB +: `SACR_SEL_BITS] == `SACR_SEL_CODE) begin
        set_ff[sh_ff[`SACR_FUNC_LSB +: `SACR_FUNC_BITS]] <= sh_ff[`SACR_VAL_LSB +: `SACR_VAL_BITS];
        upd_ff <= 1'b1;
        upd_func_ff <= sh_ff[`SACR_FUNC_LSB +: `SACR_FUNC_BITS];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_FUNCS; i++) settings[i*`SACR_VAL_BITS +: `SACR_VAL_BITS] = set_ff[i];
  end
  assign upd = upd_ff;
  assign upd_func = upd_func_ff;
endmodule // sacr_device

/* File: sacr_assertions.sv */
// Checker on the three link wires between host end and device end.
// Assumes tb_top instantiates it beside the link interface.
`timescale 1ns/1ps
module sacr_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Link.
  input wire logic data,
  input wire logic sclk,
  input wire logic en_n
);
  logic [3:0] rises_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Counts link clock rises in a frame; idle clears it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rises_ff <= 4'h0;
    else rises_ff <= en_n ? 4'h0 : rises_ff + 4'($rose(sclk));
  end
  property p_idle; en_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock while idle");
  property p_gate; $rose(sclk) |-> !en_n && !$past(en_n); endproperty
  a_gate: assert property (p_gate) else $error("edge outside frame");
  property p_hold; sclk |-> $stable(data); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_high; $rose(sclk) |-> sclk [*8] ##1 sclk [*2]; endproperty
  a_high: assert property (p_high) else $error("high too short");
  property p_low; $fell(sclk) && !en_n |-> !sclk [*8] ##1 !sclk [*2]; endproperty
  a_low: assert property (p_low) else $error("low too short");
  property p_lead; $fell(en_n) |-> !sclk [*8]; endproperty
  a_lead: assert property (p_lead) else $error("no setup");
  property p_count; $rose(en_n) |-> rises_ff == 4'hB; endproperty
  a_count: assert property (p_count) else $error("bad bit count");
  property p_end; $rose(en_n) |-> !$past(sclk, 8); endproperty
  a_end: assert property (p_end) else $error("early frame end");
endmodule // sacr_chk

/* File: tb_top.sv */
// Bench: host end sends frames to device end; settings are checked.
// Assumes design, interface and checker files compile first.
`timescale 1ns/1ps
module tb_top;
  import sacr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, req = 1'b0, busy, upd;
  logic [1:0] sel = 2'h0;
  sacr_func_t func = 3'h0, upd_func;
  sacr_val_t val = 6'h00;
  logic [47:0] settings, exp_set = 48'h0;
  logic [31:0] rnd = 32'h4436;
  // The host and the checker can be reset to cut a frame short; the device keeps running.
  logic cut_n = 1'b1, h_nrst;
  assign h_nrst = nrst & cut_n;
  int num_errors = 0, n_checks = 0, cyc = 0;
  sacr_if lnk ();
  sacr_host u_sacr_host (.clk(clk), .nrst(h_nrst), .ce(ce), .lnk(lnk), .req(req),
    .sel(sel), .func(func), .val(val), .busy(busy));
  sacr_device u_sacr_device (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk),
    .settings(settings), .upd(upd), .upd_func(upd_func));
  sacr_chk u_sacr_chk (.clk(clk), .nrst(h_nrst), .data(lnk.data), .sclk(lnk.sclk),
    .en_n(lnk.en_n));
  // The 10 MHz clock.
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One frame; the pulse window is generous since only the result counts.
  task automatic send(input logic [1:0] s, input sacr_func_t f, input sacr_val_t v);
    logic got;
    sacr_func_t gf;
    got = 1'b0;
    gf = 3'h0;
    req <= 1'b1;
    sel <= s;
    func <= f;
    val <= v;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    chk(48'(busy), 48'h1);
    while (busy !== 1'b0) @(posedge clk);
    chk(settings, exp_set);
    repeat (8) begin
      @(posedge clk);
      if (upd === 1'b1) begin
        got = 1'b1;
        gf = upd_func;
      end
    end
    if (s == 2'h2) exp_set[f * 6 +: 6] = v;
    chk(48'(got), 48'(s == 2'h2));
    if (got) chk(48'(gf), 48'(f));
    chk(settings, exp_set);
  endtask
  // Resets the host after n bits (0 to 10); the short frame must change nothing.
  task automatic cut_frame(input int n);
    logic got;
    got = 1'b0;
    req <= 1'b1;
    sel <= 2'h2;
    func <= 3'h5;
    val <= 6'h2A;
    @(posedge clk);
    req <= 1'b0;
    repeat (5 + 20 * n) @(posedge clk);
    cut_n <= 1'b0;
    @(posedge clk);
    cut_n <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      if (upd === 1'b1) got = 1'b1;
    end
    chk(48'(got), 48'h0);
    chk(settings, exp_set);
  endtask
  // Corners first: extremes and every wrong select, then random frames.
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    send(2'h2, 3'h7, 6'h3F);
    send(2'h2, 3'h0, 6'h01);
    send(2'h1, 3'h7, 6'h00);
    send(2'h0, 3'h0, 6'h3F);
    send(2'h3, 3'h7, 6'h15);
    // Input selection parked on its two open codes, as an unused selector would be.
    send(2'h2, 3'h0, 6'h30);
    send(2'h2, 3'h0, 6'h06);
    // Frames cut before the first bit, one bit short, and at a random point.
    cut_frame(0);
    cut_frame(10);
    rnd = xs(rnd);
    cut_frame(rnd[3:0] % 11);
    for (int i = 0; i < 32; i++) begin
      rnd = xs(rnd);
      send(rnd[9] ? rnd[1:0] : 2'h2, rnd[4:2], rnd[15:10]);
    end
    give_verdict();
  end
  // A hung handshake still ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      num_errors++;
      give_verdict();
    end
  end
endmodule // tb_top
